// *** src/tag_anticoll_core.v ***
`timescale 1ns/1ps
`include "tag_anticoll_defines.vh"
module tag_anticoll_core #(
   parameter BLK_DEPTH = 129
) (
   // Clock and reset.
   input  wire        i_sys_clk,
   input  wire        i_rst,
   // Request link from the reader.
   input  wire        i_link_clk,
   input  wire        i_link_rx,
   input  wire        i_link_rx_frame,
   // Reply link to the reader.
   output wire        o_link_tx,
   output reg         o_link_tx_frame,
   // Block contents load port.
   input  wire        i_blk_wr,
   input  wire [7:0]  i_blk_wr_addr,
   input  wire [31:0] i_blk_wr_data,
   // Status.
   output reg  [2:0]  o_tag_state,
   output reg  [7:0]  o_tag_handle
);

   // =====================================================
   // Shared arithmetic.
   function [15:0] crc_bit;
      input [15:0] c;
      input        b;
      begin
         if (c[0] ^ b) begin
            crc_bit = (c >> 1) ^ `CRC_POLY;
         end else begin
            crc_bit = c >> 1;
         end
      end
   endfunction

   // =====================================================
   // Request decode helpers.
   function is_cmd;
      input       ok;
      input [7:0] got;
      input [7:0] code;
      begin
         is_cmd = ok & (got == code);
      end
   endfunction

   // =====================================================
   // Input synchronisers and filters.
   reg [2:0] clk_s_q;
   reg [2:0] rx_s_q;
   reg [2:0] frm_s_q;
   reg       clk_f_q;
   reg       clk_p_q;
   reg       rx_f_q;
   reg       frm_f_q;
   reg       frm_p_q;

   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         clk_s_q <= 3'h0;
         rx_s_q  <= 3'h0;
         frm_s_q <= 3'h0;
         clk_f_q <= 1'b0;
         clk_p_q <= 1'b0;
         rx_f_q  <= 1'b0;
         frm_f_q <= 1'b0;
         frm_p_q <= 1'b0;
      end else begin
         clk_s_q <= {clk_s_q[1:0], i_link_clk};
         rx_s_q  <= {rx_s_q[1:0], i_link_rx};
         frm_s_q <= {frm_s_q[1:0], i_link_rx_frame};
         if (clk_s_q[1] == clk_s_q[2]) begin
            clk_f_q <= clk_s_q[2];
         end
         if (rx_s_q[1] == rx_s_q[2]) begin
            rx_f_q <= rx_s_q[2];
         end
         if (frm_s_q[1] == frm_s_q[2]) begin
            frm_f_q <= frm_s_q[2];
         end
         clk_p_q <= clk_f_q;
         frm_p_q <= frm_f_q;
      end
   end

   wire clk_rise  = clk_f_q & ~clk_p_q;
   wire clk_fall  = ~clk_f_q & clk_p_q;
   wire frm_start = frm_f_q & ~frm_p_q;
   wire frm_end   = ~frm_f_q & frm_p_q;

   // =====================================================
   // Random source.
   reg [15:0] lfsr_q;

   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         lfsr_q <= `LFSR_SEED;
      end else if (lfsr_q[0]) begin
         lfsr_q <= (lfsr_q >> 1) ^ 16'hB400;
      end else begin
         lfsr_q <= lfsr_q >> 1;
      end
   end

   // =====================================================
   // Request receiver.
   reg [31:0] rx_buf_q;
   reg [5:0]  rx_bits_q;
   reg [15:0] rx_crc_q;
   reg        rx_ovf_q;

   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         rx_buf_q  <= 32'h0000_0000;
         rx_bits_q <= 6'h00;
         rx_crc_q  <= `CRC_INIT;
         rx_ovf_q  <= 1'b0;
      end else if (frm_start) begin
         rx_bits_q <= 6'h00;
         rx_crc_q  <= `CRC_INIT;
         rx_ovf_q  <= 1'b0;
      end else if (frm_f_q && clk_rise) begin
         if (rx_bits_q == `RX_BITS_LONG) begin
            rx_ovf_q <= 1'b1;
         end else begin
            rx_buf_q[rx_bits_q[4:0]] <= rx_f_q;
            rx_bits_q <= rx_bits_q + 6'h01;
            rx_crc_q  <= crc_bit(rx_crc_q, rx_f_q);
         end
      end
   end

   wire [7:0] byte0    = rx_buf_q[7:0];
   wire [7:0] byte1    = rx_buf_q[15:8];
   wire       crc_ok   = (rx_crc_q == `CRC_RESIDUE) & ~rx_ovf_q;
   wire       len_one  = crc_ok & (rx_bits_q == `RX_BITS_SHORT);
   wire       len_two  = crc_ok & (rx_bits_q == `RX_BITS_LONG);
   wire       req_ok   = frm_end & (o_tag_state != `ST_DEACTIVATED);
   wire       addr_ok  = (byte1 <= `BLK_LAST_USER) | (byte1 == `BLK_SYSTEM);
   wire [7:0] rd_index = (byte1 == `BLK_SYSTEM) ? `BLK_SYS_INDEX : byte1;
   wire [31:0] blk_data;

   tag_block_store #(
      .DEPTH (BLK_DEPTH),
      .AW    (8)
   ) u_store (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_wr      (i_blk_wr),
      .i_wr_addr (i_blk_wr_addr),
      .i_wr_data (i_blk_wr_data),
      .i_rd_addr (rd_index),
      .o_rd_data (blk_data)
   );

   // =====================================================
   // Command decoder and tag state.
   reg [31:0] rep_buf_q;
   reg [2:0]  rep_len_q;
   reg        rep_pend_q;
   reg        tx_busy_q;
   reg [3:0]  slot_rand;

   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_tag_state  <= `ST_READY;
         o_tag_handle <= 8'h00;
         rep_buf_q    <= 32'h0000_0000;
         rep_len_q    <= 3'h0;
         rep_pend_q   <= 1'b0;
      end else begin
         if (frm_start || (clk_fall && rep_pend_q && !tx_busy_q)) begin
            rep_pend_q <= 1'b0;
         end
         if (is_cmd(req_ok & len_two, byte0, `CMD_SORT_HDR)) begin
            if (byte1 == `CMD_BEGIN_SORT && o_tag_state == `ST_READY) begin
               o_tag_state  <= `ST_INVENTORY;
               o_tag_handle <= lfsr_q[7:0];
               rep_buf_q    <= {24'h000000, lfsr_q[7:0]};
               rep_len_q    <= 3'h1;
               rep_pend_q   <= 1'b1;
            end else if (byte1 == `CMD_SLOT_POLL && o_tag_state == `ST_INVENTORY) begin
               o_tag_handle[3:0] <= slot_rand;
               if (slot_rand == 4'h0) begin
                  rep_buf_q  <= {24'h000000, o_tag_handle[7:4], 4'h0};
                  rep_len_q  <= 3'h1;
                  rep_pend_q <= 1'b1;
               end
            end
         end else if (req_ok && len_one && byte0[3:0] == `CMD_QUERY_LO
                      && byte0[7:4] != 4'h0) begin
            if (o_tag_state == `ST_INVENTORY
                && byte0[7:4] == o_tag_handle[3:0]) begin
               rep_buf_q  <= {24'h000000, o_tag_handle};
               rep_len_q  <= 3'h1;
               rep_pend_q <= 1'b1;
            end
         end else if (is_cmd(req_ok & len_two, byte0, `CMD_SELECT)
                      && o_tag_state != `ST_READY) begin
            if (byte1 == o_tag_handle) begin
               o_tag_state <= `ST_SELECTED;
               rep_buf_q   <= {24'h000000, o_tag_handle};
               rep_len_q   <= 3'h1;
               rep_pend_q  <= 1'b1;
            end else if (o_tag_state == `ST_SELECTED) begin
               o_tag_state <= `ST_DESELECTED;
            end
         end else if (req_ok && len_one && o_tag_state == `ST_SELECTED) begin
            if (byte0 == `CMD_FINISH) begin
               o_tag_state <= `ST_DEACTIVATED;
            end else if (byte0 == `CMD_RET_SORT) begin
               o_tag_state <= `ST_INVENTORY;
            end
         end else if (is_cmd(req_ok & len_two, byte0, `CMD_FETCH)
                      && o_tag_state == `ST_SELECTED && addr_ok) begin
            rep_buf_q  <= blk_data;
            rep_len_q  <= 3'h4;
            rep_pend_q <= 1'b1;
         end
      end
   end

   always @* begin
      slot_rand = lfsr_q[3:0];
   end

   // =====================================================
   // Reply transmitter.
   reg [31:0] tx_buf_q;
   reg [2:0]  tx_len_q;
   reg [2:0]  tx_byte_q;
   reg [2:0]  tx_bit_q;
   reg [7:0]  tx_sh_q;
   reg [15:0] tx_crc_q;
   reg [15:0] tx_crc_n;
   reg [2:0]  tx_next;

   always @* begin
      tx_next = tx_byte_q + 3'h1;
      if (tx_byte_q < tx_len_q) begin
         tx_crc_n = crc_bit(tx_crc_q, tx_sh_q[0]);
      end else begin
         tx_crc_n = tx_crc_q;
      end
   end

   assign o_link_tx = tx_sh_q[0];

   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         tx_busy_q       <= 1'b0;
         o_link_tx_frame <= 1'b0;
         tx_buf_q        <= 32'h0000_0000;
         tx_len_q        <= 3'h0;
         tx_byte_q       <= 3'h0;
         tx_bit_q        <= 3'h0;
         tx_sh_q         <= 8'h00;
         tx_crc_q        <= `CRC_INIT;
      end else if (frm_start) begin
         // A new request cuts short any reply still on the link.
         tx_busy_q       <= 1'b0;
         o_link_tx_frame <= 1'b0;
         tx_sh_q         <= 8'h00;
      end else if (clk_fall) begin
         if (!tx_busy_q) begin
            if (rep_pend_q) begin
               tx_busy_q       <= 1'b1;
               o_link_tx_frame <= 1'b1;
               tx_buf_q        <= rep_buf_q;
               tx_len_q        <= rep_len_q;
               tx_byte_q       <= 3'h0;
               tx_bit_q        <= 3'h0;
               tx_sh_q         <= rep_buf_q[7:0];
               tx_crc_q        <= `CRC_INIT;
            end
         end else begin
            tx_crc_q <= tx_crc_n;
            if (tx_bit_q != 3'h7) begin
               tx_bit_q <= tx_bit_q + 3'h1;
               tx_sh_q  <= tx_sh_q >> 1;
            end else begin
               tx_bit_q  <= 3'h0;
               tx_byte_q <= tx_next;
               tx_buf_q  <= tx_buf_q >> 8;
               if (tx_next < tx_len_q) begin
                  tx_sh_q <= tx_buf_q[15:8];
               end else if (tx_next == tx_len_q) begin
                  tx_sh_q <= ~tx_crc_n[7:0];
               end else if (tx_next == tx_len_q + 3'h1) begin
                  tx_sh_q <= ~tx_crc_n[15:8];
               end else begin
                  tx_sh_q         <= 8'h00;
                  tx_busy_q       <= 1'b0;
                  o_link_tx_frame <= 1'b0;
               end
            end
         end
      end
   end

endmodule

// *** src/tag_anticoll_defines.vh ***
`ifndef TAG_ANTICOLL_DEFINES_VH
`define TAG_ANTICOLL_DEFINES_VH

// =====================================================
// Tag states.
`define ST_READY       3'h0
`define ST_INVENTORY   3'h1
`define ST_SELECTED    3'h2
`define ST_DESELECTED  3'h3
`define ST_DEACTIVATED 3'h4

// =====================================================
// Command bytes.
`define CMD_SORT_HDR   8'h06
`define CMD_BEGIN_SORT 8'h00
`define CMD_SLOT_POLL  8'h04
`define CMD_QUERY_LO   4'h6
`define CMD_FETCH      8'h08
`define CMD_RET_SORT   8'h0C
`define CMD_SELECT     8'h0E
`define CMD_FINISH     8'h0F

// =====================================================
// Block addresses.
`define BLK_LAST_USER  8'h7F
`define BLK_SYSTEM     8'hFF
`define BLK_SYS_INDEX  8'h80

// =====================================================
// Frame check sequence.
`define CRC_INIT       16'hFFFF
`define CRC_POLY       16'h8408
`define CRC_RESIDUE    16'hF0B8

// =====================================================
// Frame sizes in bits, CRC included, and the LFSR seed.
`define RX_BITS_SHORT  6'h18
`define RX_BITS_LONG   6'h20
`define LFSR_SEED      16'hACE1

`endif

// *** src/tag_block_store.v ***
`timescale 1ns/1ps
module tag_block_store #(
   parameter DEPTH = 129,
   parameter AW    = 8
) (
   // Clock and reset.
   input  wire          i_sys_clk,
   input  wire          i_rst,
   // Load port.
   input  wire          i_wr,
   input  wire [AW-1:0] i_wr_addr,
   input  wire [31:0]   i_wr_data,
   // Read port.
   input  wire [AW-1:0] i_rd_addr,
   output reg  [31:0]   o_rd_data
);

   reg [31:0] mem [0:DEPTH-1];

   always @(posedge i_sys_clk) begin
      if (i_wr) begin
         mem[i_wr_addr] <= i_wr_data;
      end
   end

   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rd_data <= 32'h0000_0000;
      end else begin
         o_rd_data <= mem[i_rd_addr];
      end
   end

endmodule

// *** tb/reader_model.sv ***
`timescale 1ns/1ps
// ==========
// Reader side of the link.
module reader_model (
   output reg  o_lclk,
   output reg  o_rx,
   output reg  o_frame,
   input  wire i_tx,
   input  wire i_tx_frame
);
   reg [63:0] r;
   integer    rlen;
   initial begin
      o_lclk = 1'h0;
      o_rx = 1'h0;
      o_frame = 1'h0;
      rlen = 0;
   end
   // Complemented reflected CRC over the low n bits.
   function [15:0] crc(input [63:0] d, input integer n);
      integer i;
      begin
         crc = 16'hFFFF;
         for (i = 0; i < n; i = i + 1)
            crc = (crc[0] ^ d[i]) ? ((crc >> 1) ^ 16'h8408) : (crc >> 1);
         crc = ~crc;
      end
   endfunction
   // Sends n bytes and clocks the link until any reply ends.
   task send(input [47:0] pl, input integer n, input [15:0] bad);
      reg [63:0] f;
      integer    i;
      begin
         f = {16'h0000, pl};
         f[8*n +: 16] = crc(f, 8*n) ^ bad;
         rlen = 0;
         o_frame = 1'h1;
         for (i = 0; i < 8*n + 16; i = i + 1) begin
            o_rx = f[i];
            #80 o_lclk = 1'h1;
            #80 o_lclk = 1'h0;
         end
         o_frame = 1'h0;
         o_rx = ~o_rx;
         i = 0;
         while (i < 70 && (rlen == 0 ? i < 8 : i_tx_frame)) begin
            #80 o_lclk = 1'h1;
            if (i_tx_frame) begin
               r[rlen] = i_tx;
               rlen = rlen + 1;
            end
            #80 o_lclk = 1'h0;
            i = i + 1;
         end
      end
   endtask
endmodule

// *** tb/tag_anticoll_core_bench.sv ***
`timescale 1ns/1ps
// ==========
// Self-checking bench of the tag core.
module tag_anticoll_core_bench;
   reg         clk = 1'h0;
   reg         rst = 1'h1;
   reg         blk_wr = 1'h0;
   reg  [7:0]  blk_addr = 8'h00;
   reg  [31:0] blk_data = 32'h00000000;
   wire        lclk;
   wire        rx;
   wire        rx_frame;
   wire        tx;
   wire        tx_frame;
   wire [2:0]  state;
   wire [7:0]  handle;
   reg  [7:0]  h;
   reg         zero_seen;
   integer     err_count = 0;
   integer     check_count = 0;
   integer     cyc = 0;
   integer     s;
   always #5 clk = ~clk;
   tag_anticoll_core i_tag_anticoll_core (.i_sys_clk(clk), .i_rst(rst), .i_link_clk(lclk),
      .i_link_rx(rx), .i_link_rx_frame(rx_frame), .o_link_tx(tx), .o_link_tx_frame(tx_frame),
      .i_blk_wr(blk_wr), .i_blk_wr_addr(blk_addr), .i_blk_wr_data(blk_data),
      .o_tag_state(state), .o_tag_handle(handle));
   reader_model i_reader_model (.o_lclk(lclk), .o_rx(rx), .o_frame(rx_frame), .i_tx(tx),
      .i_tx_frame(tx_frame));
   task summarize;
      begin
         $display("checks %0d errors %0d", check_count, err_count);
         if (err_count == 0 && check_count > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   task check(input [63:0] seen, input [63:0] exp, input string what);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            err_count = err_count + 1;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
         end
      end
   endtask
   task load(input [7:0] a, input [31:0] d);
      begin
         @(posedge clk);
         #1 blk_wr = 1'h1;
         blk_addr = a;
         blk_data = d;
         @(posedge clk);
         #1 blk_wr = 1'h0;
      end
   endtask
   task xfer(input [47:0] pl, input integer n, input integer nb);
      begin
         i_reader_model.send(pl, n, 16'h0000);
         check(i_reader_model.rlen, nb ? 8*nb + 16 : 0, "reply bits");
         if (nb > 0)
            check(i_reader_model.r[8*nb +: 16],
               i_reader_model.crc(i_reader_model.r, 8*nb), "reply crc");
      end
   endtask
   task t_ready;
      begin
         check(state, 3'h0, "state");
         xfer(16'h7F08, 2, 0);
         xfer(16'h0406, 2, 0);
         xfer(16'h010E, 2, 0);
         check(state, 3'h0, "state");
         xfer(16'h0006, 2, 1);
         check(i_reader_model.r[7:0], handle, "handle");
         check(state, 3'h1, "state");
      end
   endtask
   task t_slots;
      begin
         h = handle;
         zero_seen = 1'b0;
         for (s = 0; s < 48 && !(zero_seen && h[3:0] != 4'h0); s = s + 1) begin
            i_reader_model.send(16'h0406, 2, 16'h0000);
            check(handle[7:4], h[7:4], "handle high part");
            h = handle;
            zero_seen = zero_seen | (h[3:0] == 4'h0);
            check(i_reader_model.rlen, h[3:0] == 4'h0 ? 24 : 0, "poll reply");
            if (h[3:0] == 4'h0)
               check(i_reader_model.r[7:0], h, "poll handle");
         end
         for (s = 1; s < 16; s = s + 1) begin
            xfer({40'h0, s[3:0], 4'h6}, 1, s == h[3:0]);
            if (s == h[3:0])
               check(i_reader_model.r[7:0], h, "query handle");
         end
         xfer(8'h06, 1, 0);
         check(handle, h, "held handle");
      end
   endtask
   task t_sel;
      begin
         i_reader_model.send({32'h0, h, 8'h0E}, 2, 16'h0001);
         check(state, 3'h1, "state");
         check(i_reader_model.rlen, 0, "bad crc reply");
         xfer({32'h0, h, 8'h0E}, 2, 1);
         check(i_reader_model.r[7:0], h, "select reply");
         check(state, 3'h2, "state");
         xfer(16'h7F08, 2, 4);
         check(i_reader_model.r[31:0], 32'hA1B2C3D4, "block");
         xfer(16'h8008, 2, 0);
         xfer(16'hFF08, 2, 4);
         check(i_reader_model.r[31:0], 32'h5E6F7081, "system block");
      end
   endtask
   task t_exit;
      begin
         xfer({32'h0, ~h, 8'h0E}, 2, 0);
         check(state, 3'h3, "state");
         xfer({32'h0, h, 8'h0E}, 2, 1);
         xfer(8'h0C, 1, 0);
         check(state, 3'h1, "state");
         xfer(8'h0F, 1, 0);
         check(state, 3'h1, "state");
         xfer({32'h0, h, 8'h0E}, 2, 1);
         xfer(8'h0F, 1, 0);
         xfer(16'h0006, 2, 0);
         check(state, 3'h4, "state");
      end
   endtask
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 90000) begin
         err_count = err_count + 1;
         summarize;
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      #1 rst = 1'h0;
      load(8'h7F, 32'hA1B2C3D4);
      load(8'h80, 32'h5E6F7081);
      repeat (4) @(posedge clk);
      #1;
      t_ready;
      t_slots;
      t_sel;
      t_exit;
      summarize;
   end
endmodule

// *** tb/tag_anticoll_core_sva.sv ***
`timescale 1ns/1ps
// ==========
// Port checks of the tag core.
module tag_anticoll_core_sva #(
   parameter BLK_DEPTH = 129
) (
   input wire       i_sys_clk,
   input wire       i_rst,
   input wire       o_link_tx_frame,
   input wire [2:0] o_tag_state,
   input wire [7:0] o_tag_handle
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);
   property p_no_ready; o_tag_state != 3'h0 |=> o_tag_state != 3'h0; endproperty
   a_no_ready: assert property (p_no_ready)
      else $error("ready state reentered");
   property p_to_inv; $changed(o_tag_state) && o_tag_state == 3'h1
      |-> $past(o_tag_state) == 3'h0 || $past(o_tag_state) == 3'h2; endproperty
   a_to_inv: assert property (p_to_inv)
      else $error("bad entry to inventory");
   property p_to_sel; $changed(o_tag_state) && o_tag_state == 3'h2
      |-> $past(o_tag_state) inside {3'h1, 3'h3}; endproperty
   a_to_sel: assert property (p_to_sel)
      else $error("bad entry to selected");
   property p_to_desel; $changed(o_tag_state) && o_tag_state == 3'h3
      |-> $past(o_tag_state) == 3'h2; endproperty
   a_to_desel: assert property (p_to_desel)
      else $error("bad entry to deselected");
   property p_to_deact; $changed(o_tag_state) && o_tag_state == 3'h4
      |-> $past(o_tag_state) == 3'h2; endproperty
   a_to_deact: assert property (p_to_deact)
      else $error("bad entry to deactivated");
   property p_lock; o_tag_state == 3'h4 |=> o_tag_state == 3'h4 [*8]; endproperty
   a_lock: assert property (p_lock)
      else $error("deactivated state left");
   property p_hold; $changed(o_tag_handle)
      |-> $past(o_tag_state) == 3'h0 || $past(o_tag_state) == 3'h1; endproperty
   a_hold: assert property (p_hold)
      else $error("handle changed outside sorting");
   property p_reply_end; $rose(o_link_tx_frame) |-> ##[1:900] !o_link_tx_frame; endproperty
   a_reply_end: assert property (p_reply_end)
      else $error("reply frame too long");
   property p_deact_quiet; o_tag_state == 3'h4 |-> !$rose(o_link_tx_frame); endproperty
   a_deact_quiet: assert property (p_deact_quiet)
      else $error("reply sent while deactivated");
   property p_id_high; $changed(o_tag_handle[7:4]) |-> $past(o_tag_state) == 3'h0; endproperty
   a_id_high: assert property (p_id_high)
      else $error("handle high part changed outside ready");
   c_sel: cover property (o_tag_state == 3'h2);
   c_deact: cover property (o_tag_state == 3'h4);
   c_reply: cover property ($rose(o_link_tx_frame));
endmodule
bind tag_anticoll_core tag_anticoll_core_sva #(.BLK_DEPTH(BLK_DEPTH)) i_tag_anticoll_core_sva (
   .i_sys_clk(i_sys_clk), .i_rst(i_rst), .o_link_tx_frame(o_link_tx_frame),
   .o_tag_state(o_tag_state), .o_tag_handle(o_tag_handle));
